// ### tb.sv
// Self-checking bench for the exit load-list and abort sequencer.
`timescale 1ns/1ps
`include "vmxab_params.svh"
module tb;
  typedef struct {
    logic [31:0] idx;
    logic [31:0] rsv;
    logic        mgmt;
    logic        nl;
    logic        gp;
    logic        bad;
  } vmxab_row_t;
  logic         clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, struct_base, reg_wr_idx, w_idx;
  logic [31:0]  mem_addr, mem_data, m_addr, m_data;
  logic         exit_start, end_in_smm, pre_fail, mcheck, mcheck_normal;
  logic         mc_enable_bit, host_loaded, entry_req, entry_vld;
  logic         no_exit_load, wr_gp_fault, wr_needs_flush, reg_wr;
  logic         tlb_flush, mem_wr, mem_ack, notify_cycle, mc_exception;
  logic         mc_shutdown, abort_parked, exit_done;
  logic [2:0]   pre_cause;
  logic [7:0]   entry_idx;
  logic [1:0]   lat;
  logic [127:0] entry_data, tab [4];
  logic [63:0]  reg_wr_val, w_val;
  logic         nl_tab [4], gp_tab [4];
  int n_errors, checked, n_wr, n_mem, n_ntf, n_mcx, n_mcd, n_fl, n_done;
  int n_ord;
  vmxab_row_t rows [8] = '{
    '{32'h0000_0010, '0, 0, 0, 0, 0},
    '{`VMXAB_IDX_FS_BASE, '0, 0, 0, 0, 1},
    '{`VMXAB_IDX_GS_BASE, '0, 0, 0, 0, 1},
    '{`VMXAB_IDX_MON_CTL, '0, 0, 0, 0, 1},
    '{`VMXAB_IDX_MON_CTL, '0, 1, 0, 0, 0},
    '{32'h0000_0010, 32'h8000_0000, 0, 0, 0, 1},
    '{32'h0000_0011, '0, 0, 1, 0, 1},
    '{32'h0000_0012, '0, 0, 0, 1, 1}};
  vmxab_seq #(.IDXW(8)) dut (.clk, .sys_rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .struct_base,
    .exit_start, .end_in_smm, .pre_fail, .pre_cause, .mcheck,
    .mcheck_normal, .mc_enable_bit, .host_loaded, .entry_idx, .entry_req,
    .entry_vld, .entry_data, .no_exit_load, .wr_gp_fault, .wr_needs_flush,
    .reg_wr, .reg_wr_idx, .reg_wr_val, .tlb_flush, .mem_wr, .mem_addr,
    .mem_data, .mem_ack, .notify_cycle, .mc_exception, .mc_shutdown,
    .abort_parked, .exit_done);
  vmxab_partner far (.clk, .sys_rst, .lat, .tab, .nl_tab, .gp_tab,
    .entry_idx, .entry_req, .entry_vld, .entry_data, .no_exit_load,
    .wr_gp_fault, .mem_wr, .mem_ack);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      n_wr++;
      w_idx = reg_wr_idx;
      w_val = reg_wr_val;
    end
    if (mem_wr === 1'b1 && mem_ack === 1'b1) begin
      n_mem++;
      m_addr = mem_addr;
      m_data = mem_data;
    end
    if (notify_cycle === 1'b1) n_ntf++;
    if (notify_cycle === 1'b1 && n_mem == 0) n_ord++;
    if (mc_exception === 1'b1) n_mcx++;
    if (mc_shutdown === 1'b1) n_mcd++;
    if (tlb_flush === 1'b1) n_fl++;
    if (exit_done === 1'b1) n_done++;
  end
  function automatic logic [127:0] ent(input logic [31:0] i, r);
    return {32'h0000_0000, ~i, r, i};
  endfunction
  task automatic conclude;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo;
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    conclude();
  endtask
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // Each transfer opens one edge late so psel is never driven twice at once.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) tmo();
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [7:0] cnt, input logic mc);
    int i;
    apb(1'b1, `VMXAB_APB_COUNT, {24'h00_0000, cnt});
    {n_wr, n_mem, n_ntf, n_mcx, n_mcd, n_fl, n_done, n_ord} = '0;
    m_data = '0;
    exit_start <= 1'b1;
    @(posedge clk);
    exit_start <= 1'b0;
    mcheck     <= mc;
    @(posedge clk);
    mcheck <= 1'b0;
    for (i = 0; i < 300; i++) begin
      if (n_done + n_mcx + n_mcd > 0 || abort_parked === 1'b1) break;
      @(posedge clk);
    end
    if (i == 300) tmo();
    repeat (4) @(posedge clk);
  endtask
  task automatic abort_chk(input logic [31:0] cause);
    chk(32'(n_mem), 32'd1);
    chk(m_addr, struct_base + `VMXAB_CAUSE_OFFSET);
    chk(m_data, cause);
    chk(32'(n_ntf + n_ord), 32'd1);
    exit_start <= 1'b1;
    mcheck     <= 1'b1;
    repeat (2) @(posedge clk);
    exit_start <= 1'b0;
    mcheck     <= 1'b0;
    repeat (8) @(posedge clk);
    chk(abort_parked, 1'b1);
    chk(32'(n_mem + n_ntf + n_mcx + n_mcd), 32'd2);
    apb(1'b0, `VMXAB_APB_CAUSE, '0);
    chk(rd, cause);
  endtask
  initial begin
    {psel, penable, pwrite, exit_start, end_in_smm, pre_fail} = '0;
    {mcheck, mcheck_normal, mc_enable_bit, host_loaded} = '0;
    {paddr, pwdata, pre_cause, wr_needs_flush} = '0;
    sys_rst = 1'b1;
    struct_base = 32'h0001_0000;
    lat = 2'b01;
    tab = '{default: '0};
    nl_tab = '{default: 1'b0};
    gp_tab = '{default: 1'b0};
    rst();
    apb(1'b0, `VMXAB_APB_CAUSE, '0);
    chk(rd, '0);
    apb(1'b0, `VMXAB_APB_CTRL, '0);
    chk(err, 1'b1);
    apb(1'b1, `VMXAB_APB_COUNT, 32'h0000_0103);
    apb(1'b0, `VMXAB_APB_COUNT, '0);
    chk(rd[7:0], 8'h03);
    for (int r = 0; r < 8; r++) begin
      rst();
      tab[0]     <= ent(rows[r].idx, rows[r].rsv);
      nl_tab[0]  <= rows[r].nl;
      gp_tab[0]  <= rows[r].gp;
      end_in_smm <= rows[r].mgmt;
      lat        <= 2'(r);
      go(8'h01, 1'b0);
      if (rows[r].bad) begin
        abort_chk(`VMXAB_CAUSE_HLOAD);
      end else begin
        chk({w_val, w_idx}, {32'h0000_0000, ~rows[r].idx, rows[r].idx});
        chk(32'(n_wr + n_done + n_mem), 32'd2);
      end
    end
    rst();
    tab <= '{ent(32'h0000_0010, '0), ent(`VMXAB_IDX_GS_BASE, '0),
             ent(32'h0000_0011, '0), '0};
    end_in_smm <= 1'b0;
    nl_tab <= '{default: 1'b0};
    gp_tab <= '{default: 1'b0};
    go(8'h03, 1'b0);
    chk({32'(n_wr), w_idx}, {32'd1, 32'h0000_0010});
    abort_chk(`VMXAB_CAUSE_HLOAD);
    rst();
    tab <= '{ent(32'h0000_0020, '0), ent(32'h0000_0021, '0),
             ent(32'h0000_0022, '0), '0};
    wr_needs_flush <= 1'b1;
    go(8'h03, 1'b0);
    chk({32'(n_wr), w_idx}, {32'd3, 32'h0000_0022});
    chk(32'(n_fl + n_done), 32'd2);
    wr_needs_flush <= 1'b0;
    go(8'h00, 1'b0);
    chk(32'(n_done + n_wr + n_fl), 32'd1);
    for (int c = 0; c < 8; c++) begin
      rst();
      pre_fail  <= 1'b1;
      pre_cause <= 3'(c);
      go(8'h01, 1'b0);
      abort_chk((c == 0 || c > 5) ? `VMXAB_CAUSE_CORRUPT : 32'(c));
    end
    pre_fail <= 1'b0;
    lat      <= 2'b11;
    for (int k = 0; k < 2; k++) begin
      rst();
      mcheck_normal <= 1'b1;
      mc_enable_bit <= k[0];
      go(8'h01, 1'b1);
      chk({32'(n_mcx), 32'(n_mcd), 32'(n_mem)}, {32'(k), 32'(1 - k), 32'd0});
    end
    for (int k = 0; k < 2; k++) begin
      rst();
      mcheck_normal <= k[0];
      host_loaded   <= k[0];
      go(8'h01, 1'b1);
      abort_chk(`VMXAB_CAUSE_MCHECK);
    end
    conclude();
  end
endmodule

// ### vmxab_params.svh
// Constants for the exit model-register load and abort sequencer.
`ifndef VMXAB_PARAMS_SVH
`define VMXAB_PARAMS_SVH
`define VMXAB_IDX_FS_BASE    32'hC000_0100
`define VMXAB_IDX_GS_BASE    32'hC000_0101
`define VMXAB_IDX_MON_CTL    32'h0000_009B
`define VMXAB_IDX_LSB        0
`define VMXAB_IDX_MSB        31
`define VMXAB_RSV_LSB        32
`define VMXAB_RSV_MSB        63
`define VMXAB_VAL_LSB        64
`define VMXAB_VAL_MSB        127
`define VMXAB_CAUSE_OFFSET   32'h0000_0004
`define VMXAB_CAUSE_NONE     32'h0000_0000
`define VMXAB_CAUSE_GSAVE    32'h0000_0001
`define VMXAB_CAUSE_PAGE_DIR_POINTER_ENTRIES    32'h0000_0002
`define VMXAB_CAUSE_CORRUPT  32'h0000_0003
`define VMXAB_CAUSE_HLOAD    32'h0000_0004
`define VMXAB_CAUSE_MCHECK   32'h0000_0005
`define VMXAB_APB_CTRL       12'h000
`define VMXAB_APB_COUNT      12'h004
`define VMXAB_APB_STATUS     12'h008
`define VMXAB_APB_CAUSE      12'h00C
`define VMXAB_APB_ENTRY      12'h010
`endif

// ### vmxab_partner.sv
// Load-list memory and chipset model facing the exit sequencer.
`timescale 1ns/1ps
module vmxab_partner (
  input  wire logic         clk,          // Core clock
  input  wire logic         sys_rst,      // Async reset, active high
  input  wire logic [1:0]   lat,          // Answer delay in cycles
  input  wire logic [127:0] tab [4],      // Entry contents
  input  wire logic         nl_tab [4],   // Entry barred on exit
  input  wire logic         gp_tab [4],   // Entry write would fault
  input  wire logic [7:0]   entry_idx,    // Requested entry
  input  wire logic         entry_req,    // Fetch request
  output logic              entry_vld,    // Entry valid pulse
  output logic      [127:0] entry_data,   // Entry contents
  output logic              no_exit_load, // Held entry barred
  output logic              wr_gp_fault,  // Held entry faults
  input  wire logic         mem_wr,       // Cause write request
  output logic              mem_ack       // Cause write taken
);
  logic [1:0] ewait_reg;
  logic [1:0] mwait_reg;
  // Idle data lines toggle so a stale entry cannot pass for a fresh one.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      entry_vld    <= 1'b0;
      entry_data   <= '0;
      no_exit_load <= 1'b0;
      wr_gp_fault  <= 1'b0;
      ewait_reg    <= 2'b00;
    end else if (entry_req && !entry_vld && ewait_reg == lat) begin
      entry_vld    <= 1'b1;
      entry_data   <= tab[entry_idx[1:0]];
      no_exit_load <= nl_tab[entry_idx[1:0]];
      wr_gp_fault  <= gp_tab[entry_idx[1:0]];
      ewait_reg    <= 2'b00;
    end else begin
      entry_vld  <= 1'b0;
      entry_data <= ~entry_data;
      ewait_reg  <= entry_req ? ewait_reg + 2'd1 : 2'b00;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack   <= 1'b0;
      mwait_reg <= 2'b00;
    end else begin
      mem_ack   <= mem_wr && !mem_ack && mwait_reg == lat;
      mwait_reg <= (mem_wr && !mem_ack) ? mwait_reg + 2'd1 : 2'b00;
    end
  end
endmodule

// ### vmxab_pkg.sv
// Types for the exit model-register load and abort sequencer.
package vmxab_pkg;
  typedef enum logic [2:0] {
    VMXAB_IDLE   = 3'b000,
    VMXAB_FETCH  = 3'b001,
    VMXAB_CHECK  = 3'b011,
    VMXAB_WRITE  = 3'b010,
    VMXAB_CAUSE  = 3'b110,
    VMXAB_NOTIFY = 3'b111,
    VMXAB_PARK   = 3'b101,
    VMXAB_DONE   = 3'b100
  } vmxab_state_t;
endpackage

// ### vmxab_seq.sv
// Exit load-list walker with abort, notification and shutdown handling.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "vmxab_params.svh"
module vmxab_seq #(
  parameter int IDXW = 8                     // Entry index width
) (
  input  wire logic        clk,              // Core clock, 25 MHz
  input  wire logic        sys_rst,          // Async reset, active high
  input  wire logic [11:0] paddr,            // APB address
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB direction
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  input  wire logic [31:0] struct_base,      // Control structure address
  input  wire logic        exit_start,       // Exit begins, pulse
  input  wire logic        end_in_smm,       // Exit finishes in SYSTEM_MANAGEMENT_MODE
  input  wire logic        pre_fail,         // Earlier exit step failed
  input  wire logic [2:0]  pre_cause,        // Its cause code
  input  wire logic        mcheck,           // Machine check, pulse
  input  wire logic        mcheck_normal,    // Prefer normal handling
  input  wire logic        mc_enable_bit,    // Machine-check enable bit
  input  wire logic        host_loaded,      // Host state already loaded
  output logic [IDXW-1:0]  entry_idx,        // Entry being fetched
  output logic             entry_req,        // Entry fetch request
  input  wire logic        entry_vld,        // Entry data valid
  input  wire logic [127:0] entry_data,      // Entry contents
  input  wire logic        no_exit_load,     // Index barred on exit
  input  wire logic        wr_gp_fault,      // Write would fault at CURRENT_PRIVILEGE_LEVEL 0
  input  wire logic        wr_needs_flush,   // Write requires TLB flush
  output logic             reg_wr,           // Model register write pulse
  output logic      [31:0] reg_wr_idx,       // Write index
  output logic      [63:0] reg_wr_val,       // Write value
  output logic             tlb_flush,        // Translation flush pulse
  output logic             mem_wr,           // Cause write request, held until taken
  output logic      [31:0] mem_addr,         // Cause write address
  output logic      [31:0] mem_data,         // Cause write data
  input  wire logic        mem_ack,          // Cause write taken
  output logic             notify_cycle,     // Special bus cycle pulse
  output logic             mc_exception,     // Deliver via guest table
  output logic             mc_shutdown,      // Plain shutdown
  output logic             abort_parked,     // Abort shutdown state
  output logic             exit_done         // Exit completed pulse
);
  vmxab_pkg::vmxab_state_t state_reg;
  logic [IDXW-1:0] count_reg;
  logic [IDXW-1:0] idx_reg;
  logic [31:0]     cause_reg;
  logic [127:0]    ent_reg;
  logic            flush_pend_reg;
  logic            done_cnt_reg;
  logic            entry_bad;
  logic            abort_now;
  logic [31:0]     pre_code;
  logic            apb_acc;
  logic            apb_map;
  logic            mc_abort;

  assign pre_code = {29'h0000_0000, pre_cause};
  // Only the walking states abort on a check, so the cause word stands
  // still while it is written. A loaded entry is host state, so normal
  // handling is left only before the first entry has been written.
  assign mc_abort = mcheck &&
                    (state_reg == vmxab_pkg::VMXAB_FETCH ||
                     state_reg == vmxab_pkg::VMXAB_CHECK ||
                     state_reg == vmxab_pkg::VMXAB_WRITE) &&
                    (!mcheck_normal || host_loaded || idx_reg != '0 ||
                     state_reg != vmxab_pkg::VMXAB_FETCH);

  assign entry_bad =
    ent_reg[`VMXAB_IDX_MSB:`VMXAB_IDX_LSB] == `VMXAB_IDX_FS_BASE ||
    ent_reg[`VMXAB_IDX_MSB:`VMXAB_IDX_LSB] == `VMXAB_IDX_GS_BASE ||
    (ent_reg[`VMXAB_IDX_MSB:`VMXAB_IDX_LSB] == `VMXAB_IDX_MON_CTL &&
     !end_in_smm) ||
    no_exit_load ||
    ent_reg[`VMXAB_RSV_MSB:`VMXAB_RSV_LSB] != 32'h0000_0000 ||
    wr_gp_fault;
  assign abort_now = state_reg == vmxab_pkg::VMXAB_CHECK && entry_bad;

  // Sequencer; the parked state has no exit but reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= vmxab_pkg::VMXAB_IDLE;
    end else begin
      unique case (state_reg)
        vmxab_pkg::VMXAB_IDLE: begin
          if (exit_start && pre_fail) begin
            state_reg <= vmxab_pkg::VMXAB_CAUSE;
          end else if (exit_start) begin
            state_reg <= vmxab_pkg::VMXAB_FETCH;
          end
        end
        vmxab_pkg::VMXAB_FETCH: begin
          if (mc_abort) begin
            state_reg <= vmxab_pkg::VMXAB_CAUSE;
          end else if (mcheck && state_reg != vmxab_pkg::VMXAB_IDLE) begin
            state_reg <= vmxab_pkg::VMXAB_DONE;
          end else if (idx_reg == count_reg) begin
            state_reg <= vmxab_pkg::VMXAB_DONE;
          end else if (entry_vld) begin
            state_reg <= vmxab_pkg::VMXAB_CHECK;
          end
        end
        vmxab_pkg::VMXAB_CHECK: begin
          if (mc_abort || entry_bad) begin
            state_reg <= vmxab_pkg::VMXAB_CAUSE;
          end else begin
            state_reg <= vmxab_pkg::VMXAB_WRITE;
          end
        end
        vmxab_pkg::VMXAB_WRITE: begin
          state_reg <= mc_abort ? vmxab_pkg::VMXAB_CAUSE
                                : vmxab_pkg::VMXAB_FETCH;
        end
        vmxab_pkg::VMXAB_CAUSE: begin
          if (mem_ack) begin
            state_reg <= vmxab_pkg::VMXAB_NOTIFY;
          end
        end
        vmxab_pkg::VMXAB_NOTIFY: state_reg <= vmxab_pkg::VMXAB_PARK;
        vmxab_pkg::VMXAB_PARK:   state_reg <= vmxab_pkg::VMXAB_PARK;
        vmxab_pkg::VMXAB_DONE:   state_reg <= vmxab_pkg::VMXAB_IDLE;
      endcase
    end
  end

  // Cause is latched once per abort; the first detected cause wins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_reg <= `VMXAB_CAUSE_NONE;
    end else if (state_reg == vmxab_pkg::VMXAB_IDLE && exit_start &&
                 pre_fail) begin
      cause_reg <= (pre_code == `VMXAB_CAUSE_NONE || pre_code >
                    `VMXAB_CAUSE_MCHECK) ? `VMXAB_CAUSE_CORRUPT
                                        : pre_code;
    end else if (mc_abort) begin
      cause_reg <= `VMXAB_CAUSE_MCHECK;
    end else if (abort_now) begin
      cause_reg <= `VMXAB_CAUSE_HLOAD;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_reg <= '0;
      ent_reg <= '0;
    end else if (state_reg == vmxab_pkg::VMXAB_IDLE) begin
      idx_reg <= '0;
    end else if (state_reg == vmxab_pkg::VMXAB_FETCH && entry_vld) begin
      ent_reg <= entry_data;
    end else if (state_reg == vmxab_pkg::VMXAB_WRITE) begin
      idx_reg <= idx_reg + 1'b1;
    end
  end

  // Flush is deferred to exit completion so one flush covers all loads.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_pend_reg <= 1'b0;
    end else if (state_reg == vmxab_pkg::VMXAB_IDLE) begin
      flush_pend_reg <= 1'b0;
    end else if (state_reg == vmxab_pkg::VMXAB_WRITE && wr_needs_flush) begin
      flush_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mc_exception <= 1'b0;
      mc_shutdown  <= 1'b0;
    end else if (mcheck && !mc_abort &&
                 (state_reg == vmxab_pkg::VMXAB_FETCH)) begin
      mc_exception <= mc_enable_bit;
      mc_shutdown  <= !mc_enable_bit;
    end else begin
      mc_exception <= 1'b0;
      mc_shutdown  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_cnt_reg <= 1'b0;
    end else begin
      done_cnt_reg <= state_reg == vmxab_pkg::VMXAB_DONE;
    end
  end

  assign entry_req    = state_reg == vmxab_pkg::VMXAB_FETCH &&
                        idx_reg != count_reg;
  assign entry_idx    = idx_reg;
  assign reg_wr       = state_reg == vmxab_pkg::VMXAB_WRITE;
  assign reg_wr_idx   = ent_reg[`VMXAB_IDX_MSB:`VMXAB_IDX_LSB];
  assign reg_wr_val   = ent_reg[`VMXAB_VAL_MSB:`VMXAB_VAL_LSB];
  assign tlb_flush    = state_reg == vmxab_pkg::VMXAB_DONE && flush_pend_reg;
  // Only the cause word is ever written to the structure.
  assign mem_wr       = state_reg == vmxab_pkg::VMXAB_CAUSE;
  assign mem_addr     = struct_base + `VMXAB_CAUSE_OFFSET;
  assign mem_data     = cause_reg;
  assign notify_cycle = state_reg == vmxab_pkg::VMXAB_NOTIFY;
  assign abort_parked = state_reg == vmxab_pkg::VMXAB_PARK;
  assign exit_done    = done_cnt_reg;

  // APB slave: zero wait states, unmapped addresses error.
  assign apb_acc = psel && penable;
  assign pready  = 1'b1;
  assign apb_map = paddr == `VMXAB_APB_COUNT || paddr == `VMXAB_APB_STATUS ||
                   paddr == `VMXAB_APB_CAUSE || paddr == `VMXAB_APB_ENTRY;
  assign pslverr = apb_acc && !apb_map;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (apb_acc && pwrite && paddr == `VMXAB_APB_COUNT &&
                 state_reg == vmxab_pkg::VMXAB_IDLE) begin
      count_reg <= pwdata[IDXW-1:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == `VMXAB_APB_COUNT) begin
      prdata[IDXW-1:0] = count_reg;
    end else if (paddr == `VMXAB_APB_STATUS) begin
      prdata[2:0] = state_reg;
    end else if (paddr == `VMXAB_APB_CAUSE) begin
      prdata = cause_reg;
    end else if (paddr == `VMXAB_APB_ENTRY) begin
      prdata[IDXW-1:0] = idx_reg;
    end
  end

  AST_PARK_STAYS: assert property (
    @(posedge clk) disable iff (sys_rst) abort_parked |=> abort_parked)
    else $error("Left abort shutdown without reset.");

  AST_NOTIFY_THEN_PARK: assert property (
    @(posedge clk) disable iff (sys_rst) notify_cycle |=> abort_parked)
    else $error("Notify not followed by parking.");

  AST_CAUSE_VALID: assert property (
    @(posedge clk) disable iff (sys_rst)
    mem_wr |-> mem_data >= 32'h0000_0001 && mem_data <= 32'h0000_0005)
    else $error("Bad cause code written.");

  AST_BAD_NO_WRITE: assert property (
    @(posedge clk) disable iff (sys_rst)
    abort_now && !mc_abort |=> !reg_wr ##1 mem_wr)
    else $error("Failed entry still written.");

  AST_HLOAD_CAUSE: assert property (
    @(posedge clk) disable iff (sys_rst)
    abort_now && !mc_abort |=> mem_data == 32'h0000_0004)
    else $error("Load failure cause not 4.");

  AST_RSV_FAIL: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_CHECK && ent_reg[63:32] != 32'h0 |=>
    state_reg == vmxab_pkg::VMXAB_CAUSE)
    else $error("Reserved bits not refused.");

  AST_FS_FAIL: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_CHECK && ent_reg[31:0] == 32'hC000_0100
    |=> !reg_wr)
    else $error("FS base entry loaded.");

  AST_MC_ABORT: assert property (
    @(posedge clk) disable iff (sys_rst)
    mc_abort |=> mem_wr && mem_data == 32'h0000_0005)
    else $error("Machine check abort cause not 5.");

  AST_MC_HOST: assert property (
    @(posedge clk) disable iff (sys_rst)
    host_loaded |-> !mc_exception || $past(!host_loaded))
    else $error("Normal check after host load.");

  AST_IDLE_QUIET: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_IDLE |-> !mem_wr && !notify_cycle)
    else $error("Structure touched while idle.");

  AST_GS_FAIL: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_CHECK && ent_reg[31:0] == 32'hC000_0101
    |=> state_reg == vmxab_pkg::VMXAB_CAUSE)
    else $error("GS base entry not refused.");

  AST_MON_FAIL: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_CHECK && ent_reg[31:0] == 32'h0000_009B
    && !end_in_smm |=> state_reg == vmxab_pkg::VMXAB_CAUSE)
    else $error("Monitor control entry not refused.");

  AST_MON_SMM_OK: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_CHECK && ent_reg[31:0] == 32'h0000_009B
    && end_in_smm && !no_exit_load && !wr_gp_fault && !mcheck &&
    ent_reg[63:32] == 32'h0000_0000 |=> reg_wr)
    else $error("Monitor control entry refused in SYSTEM_MANAGEMENT_MODE.");

  AST_NL_FAIL: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_CHECK && no_exit_load |=>
    state_reg == vmxab_pkg::VMXAB_CAUSE)
    else $error("Barred entry not refused.");

  AST_GP_FAIL: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_CHECK && wr_gp_fault |=>
    state_reg == vmxab_pkg::VMXAB_CAUSE)
    else $error("Faulting entry not refused.");

  AST_WRITE_ONCE: assert property (
    @(posedge clk) disable iff (sys_rst) reg_wr |=> !reg_wr)
    else $error("Entry written twice.");

  AST_IDX_STEP: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr |=> entry_idx == $past(entry_idx) + 1'b1)
    else $error("Entry index did not advance.");

  AST_REQ_BOUND: assert property (
    @(posedge clk) disable iff (sys_rst) entry_req |-> entry_idx < count_reg)
    else $error("Entry fetched beyond count.");

  AST_MEM_HOLD: assert property (
    @(posedge clk) disable iff (sys_rst)
    mem_wr && !mem_ack |=> mem_wr && $stable(mem_data))
    else $error("Cause write not held.");

  AST_MEM_ADDR: assert property (
    @(posedge clk) disable iff (sys_rst)
    mem_wr |-> mem_addr == struct_base + 32'h0000_0004)
    else $error("Cause written to wrong address.");

  AST_NOTIFY_AFTER: assert property (
    @(posedge clk) disable iff (sys_rst) mem_wr && mem_ack |=> notify_cycle)
    else $error("No notify after cause write.");

  AST_NOTIFY_ONCE: assert property (
    @(posedge clk) disable iff (sys_rst) notify_cycle |=> !notify_cycle)
    else $error("Notify longer than one cycle.");

  AST_PARK_SILENT: assert property (
    @(posedge clk) disable iff (sys_rst)
    abort_parked |-> !mem_wr && !notify_cycle && !reg_wr && !entry_req &&
    !mc_exception && !mc_shutdown)
    else $error("Activity while parked.");

  AST_PARK_NO_DONE: assert property (
    @(posedge clk) disable iff (sys_rst)
    abort_parked |=> !exit_done && !tlb_flush)
    else $error("Exit completed while parked.");

  AST_MC_EXCL: assert property (
    @(posedge clk) disable iff (sys_rst) !(mc_exception && mc_shutdown))
    else $error("Exception and shutdown together.");

  AST_MC_NORMAL: assert property (
    @(posedge clk) disable iff (sys_rst)
    mcheck && state_reg == vmxab_pkg::VMXAB_FETCH && mcheck_normal &&
    !host_loaded && entry_idx == '0 |=>
    mc_exception == $past(mc_enable_bit) &&
    mc_shutdown == !$past(mc_enable_bit) && !mem_wr)
    else $error("Normal machine check mishandled.");

  AST_MC_LOADED: assert property (
    @(posedge clk) disable iff (sys_rst)
    mcheck && state_reg == vmxab_pkg::VMXAB_FETCH && entry_idx != '0 |=>
    !mc_exception && !mc_shutdown && mem_wr)
    else $error("Normal check after an entry was loaded.");

  AST_PRE_FAIL: assert property (
    @(posedge clk) disable iff (sys_rst)
    state_reg == vmxab_pkg::VMXAB_IDLE && exit_start && pre_fail |=>
    mem_wr && mem_data >= 32'h0000_0001 && mem_data <= 32'h0000_0005)
    else $error("Earlier failure not aborted.");

  AST_TLB_DONE: assert property (
    @(posedge clk) disable iff (sys_rst) tlb_flush |=> exit_done)
    else $error("Flush outside exit completion.");

  AST_DONE_ONCE: assert property (
    @(posedge clk) disable iff (sys_rst) exit_done |=> !exit_done)
    else $error("Exit done longer than one cycle.");
endmodule
